// ===== tb/fetch_model.sv
// refresh fetch side: one frame pulse, then LINES line pulses
// assumes go is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none
module fetch_model #(parameter int LINES = 3) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	output logic frameStart,
	output logic lineStart
);
	logic [3:0] cnt;
	// frame pulse, then back to back line pulses
	always_ff @(posedge clk) begin
		frameStart <= go & !sys_rst;
		if (sys_rst) cnt <= 4'h0;
		else if (frameStart) cnt <= 4'(LINES);
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
	end
	assign lineStart = cnt != 4'h0;
endmodule : fetch_model
`default_nettype wire

// ===== tb/viewport_start_asserts.sv
// port checks for the viewport start block
// assumes bind onto viewport_start, one clock domain
`timescale 1ns/1ps
`default_nettype none
module viewport_start_asserts
	import viewport_pkg::*;
#(parameter int MEM_BYTES = 81920) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic frameStart,
	input wire logic lineStart,
	input wire fetch_s fetchInfo,
	input wire logic [17:0] lineAddr,
	input wire logic addrInRange
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_wrrd;
		regWr ##1 regRd && regAddr == $past(regAddr)
		&& regAddr inside {8'h0C, 8'h0D, 8'h10};
	endsequence
	sequence s_line1; frameStart ##1 lineStart; endsequence
	property p_rdback; s_wrrd |=> regRdData == $past(regWrData, 2); endproperty
	property p_idle; !regRd |=> regRdData == 8'h00; endproperty
	property p_first; s_line1 |=> lineAddr == $past(fetchInfo.byteAddr);
	endproperty
	property p_next; lineStart && !$past(frameStart) |=>
		lineAddr == $past(lineAddr) + $past(fetchInfo.lineStrideBytes);
	endproperty
	property p_range; addrInRange == (lineAddr < MEM_BYTES); endproperty
	property p_snap; !frameStart |=> $stable(fetchInfo); endproperty
	property p_pan;
		fetchInfo.panPixels inside {5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
	endproperty
	property p_even; fetchInfo.lineStrideBytes[0] == 1'b0; endproperty
	a_rdback: assert property (p_rdback) else $error("readback");
	a_idle: assert property (p_idle) else $error("read idle");
	a_first: assert property (p_first) else $error("first line");
	a_next: assert property (p_next) else $error("stride");
	a_range: assert property (p_range) else $error("range");
	a_snap: assert property (p_snap) else $error("snapshot");
	a_pan: assert property (p_pan) else $error("pan step");
	a_even: assert property (p_even) else $error("odd stride");
endmodule : viewport_start_asserts
bind viewport_start viewport_start_asserts #(.MEM_BYTES(MEM_BYTES)) i_chk (
	.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.frameStart(frameStart), .lineStart(lineStart), .fetchInfo(fetchInfo),
	.lineAddr(lineAddr), .addrInRange(addrInRange));
`default_nettype wire

// ===== tb/viewport_start_test.sv
// bench for the viewport start block with the fetch model
// assumes a 100 MHz clock and six reset cycles
`timescale 1ns/1ps
`default_nettype none
module viewport_start_test;
	import viewport_pkg::*;
	logic clk = 0, sys_rst = 1, regWr = 0, regRd = 0, go = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
	logic frameStart, lineStart, addrInRange;
	logic [17:0] lineAddr;
	fetch_s fetchInfo;
	int err_count = 0, num_checks = 0;
	viewport_start i_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .frameStart(frameStart),
		.lineStart(lineStart), .fetchInfo(fetchInfo), .lineAddr(lineAddr),
		.addrInRange(addrInRange));
	fetch_model i_fetch (.clk(clk), .sys_rst(sys_rst), .go(go),
		.frameStart(frameStart), .lineStart(lineStart));
	initial forever #5 clk = ~clk;
	task chk(input logic [17:0] s, input logic [17:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) {regWr, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge clk) regWr <= 1'b0;
	endtask : wr
	task rdq(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) {regRd, regAddr} <= {1'b1, a};
		@(posedge clk) regRd <= 1'b0;
		#1 d = regRdData;
	endtask : rdq
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rdq(a, d);
		chk(d, e);
	endtask : rd
	// write then read back with no gap between the strobes
	task wrrd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) {regWr, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge clk) {regWr, regRd} <= 2'b01;
		@(posedge clk) regRd <= 1'b0;
		#1 chk(regRdData, d);
	endtask : wrrd
	task frame;
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask : frame
	task end_of_test;
		$display("errors %0d checks %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		#20000;
		err_count++;
		end_of_test();
	end
	task test_regs;
		rd(8'h0C, 8'h00);
		wr(8'h0C, 8'h80);
		wr(8'h0D, 8'h0C);
		wr(8'h10, 8'hFF);
		wr(8'h20, 8'h55);
		rd(8'h0C, 8'h80);
		rd(8'h0D, 8'h0C);
		rd(8'h10, 8'hFF);
		rd(8'h20, 8'h00);
		wrrd(8'h0D, 8'h5A);
		wrrd(8'h0D, 8'h0C);
	endtask : test_regs
	task test_pan;
		for (int o = 0; o < 2; o++) for (int d = 0; d < 4; d++) begin
			wr(8'h13, {5'h00, o[0], d[1:0]});
			frame();
			chk(fetchInfo.panPixels, (o ? 18'h8 : 18'h10) >> d);
		end
	endtask : test_pan
	task test_landscape;
		wr(8'h12, 8'h80);
		wr(8'h11, 8'h28);
		wr(8'h13, 8'h02);
		frame();
		chk(fetchInfo.byteAddr, 18'h21900);
		chk(fetchInfo.lineStrideBytes, 18'h150);
		chk(lineAddr, 18'h21BA0);
		chk(addrInRange, 18'h0);
	endtask : test_landscape
	task test_portrait;
		wr(8'h10, 8'h00);
		wr(8'h0C, 8'h81);
		wr(8'h13, 8'h07);
		frame();
		chk(fetchInfo.byteAddr, 18'hC81);
		chk(lineAddr, 18'hF21);
		chk(addrInRange, 18'h1);
	endtask : test_portrait
	// software scroll by one virtual line: 80h plus 28h words
	task scroll(input logic up, input logic [17:0] e);
		logic [7:0] lo, mi, hi;
		int w;
		rdq(8'h0C, lo);
		rdq(8'h0D, mi);
		rdq(8'h10, hi);
		w = {hi[0], mi, lo};
		w = up ? w - 'hA8 : w + 'hA8;
		if (w < 0) w = 0;
		wr(8'h10, {7'h00, w[16]});
		wr(8'h0D, w[15:8]);
		wr(8'h0C, w[7:0]);
		frame();
		chk(fetchInfo.byteAddr, e);
	endtask : scroll
	task test_scroll;
		wr(8'h13, 8'h02);
		wr(8'h10, 8'h00);
		wr(8'h0D, 8'h00);
		wr(8'h0C, 8'h50);
		scroll(1'b1, 18'h0);
		scroll(1'b0, 18'h150);
		scroll(1'b0, 18'h2A0);
		scroll(1'b1, 18'h150);
	endtask : test_scroll
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		test_regs();
		test_pan();
		test_landscape();
		test_portrait();
		test_scroll();
		end_of_test();
	end
endmodule : viewport_start_test
`default_nettype wire

// ===== verilog/viewport_consts.svh
// constant definitions for the viewport start address block
// assumes inclusion by bare name from the design package and module
`ifndef VIEWPORT_CONSTS_SVH
`define VIEWPORT_CONSTS_SVH
`define ADDR_START_LOW 8'h0C
`define ADDR_START_MID 8'h0D
`define ADDR_START_HIGH 8'h10
`define ADDR_LINE_OFFSET 8'h11
`define ADDR_LINE_WIDTH 8'h12
`define ADDR_MODE 8'h13
`define RESET_BYTE 8'h00
`define RESET_ADDR 17'h00000
`define MEM_BYTES 81920
`define MODE_PORTRAIT_BIT 2
`define RESET_MODE 3'h0
`define RESET_LINE_ADDR 18'h00000
`define PAN_1BPP 5'h10
`define PAN_2BPP 5'h08
`define PAN_4BPP 5'h04
`define PAN_8BPP 5'h02
`endif

// ===== verilog/viewport_pkg.sv
// types shared by the viewport start address block
// assumes the constants header sits beside it
`default_nettype none
`include "viewport_consts.svh"
package viewport_pkg;
	typedef enum logic [1:0] {
		DEPTH_1 = 2'h0,
		DEPTH_2 = 2'h1,
		DEPTH_4 = 2'h2,
		DEPTH_8 = 2'h3
	} depth_e;
	typedef struct packed {
		logic portrait;
		depth_e depth;
	} mode_s;
	typedef struct packed {
		logic [17:0] byteAddr;
		logic [17:0] lineStrideBytes;
		logic [4:0] panPixels;
	} fetch_s;
endpackage : viewport_pkg
`default_nettype wire

// ===== verilog/viewport_start.sv
// frame start address and line stride generation for the screen viewport
// assumes a plain one-cycle register port and a frame start pulse on clk
`timescale 1ns/1ps
`default_nettype none
`include "viewport_consts.svh"
module viewport_start
	import viewport_pkg::*;
#(
	parameter int MEM_BYTES = `MEM_BYTES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic frameStart,
	input wire logic lineStart,
	output fetch_s fetchInfo,
	output logic [17:0] lineAddr,
	output logic addrInRange
);
	// byte registers as software programmed them
	logic [7:0] startLow_reg;
	logic [7:0] startMid_reg;
	logic [7:0] startHigh_reg;
	logic [7:0] lineOffset_reg;
	logic [7:0] lineWidth_reg;
	mode_s mode_reg;

	// copies taken at each frame start
	logic [16:0] frameStart_reg;
	mode_s frameMode_reg;
	logic [7:0] frameOffset_reg;
	logic [7:0] frameWidth_reg;

	// line walk state
	logic [17:0] lineAddr_reg;
	logic [17:0] lineAddr_next;
	logic [17:0] stride;
	logic firstLine_reg;

	// register decode and readback
	logic hitLow;
	logic hitMid;
	logic hitHigh;
	logic hitOffset;
	logic hitWidth;
	logic hitMode;
	logic [7:0] rdValue;
	logic [16:0] startWord;

	// pixels moved by one address unit
	function automatic logic [4:0] pan_step(input mode_s m);
		logic [4:0] w;
		w = `PAN_1BPP;
		unique case (m.depth)
			DEPTH_1: w = `PAN_1BPP;
			DEPTH_2: w = `PAN_2BPP;
			DEPTH_4: w = `PAN_4BPP;
			DEPTH_8: w = `PAN_8BPP;
		endcase
		return m.portrait ? (w >> 1) : w;
	endfunction : pan_step

	// one register address compare, shared by write and read paths
	function automatic logic reg_hit(
		input logic [7:0] a,
		input logic [7:0] target
	);
		return a == target;
	endfunction : reg_hit

	// three byte registers joined into the start word
	function automatic logic [16:0] join_start(
		input logic [7:0] hi,
		input logic [7:0] mid,
		input logic [7:0] lo
	);
		return {hi[0], mid, lo};
	endfunction : join_start

	// start word to a byte address, by orientation
	function automatic logic [17:0] start_bytes(
		input mode_s m,
		input logic [16:0] s
	);
		logic [17:0] b;
		b = {s, 1'b0};
		if (m.portrait) begin
			b = {1'b0, s};
		end
		return b;
	endfunction : start_bytes

	// virtual line in bytes: physical plus extra words, two bytes each
	function automatic logic [17:0] stride_bytes(
		input logic [7:0] width,
		input logic [7:0] extra
	);
		logic [17:0] wsum;
		wsum = {10'h000, width} + {10'h000, extra};
		return {wsum[16:0], 1'b0};
	endfunction : stride_bytes

	// inside the display memory the image lives in
	function automatic logic in_memory(input logic [17:0] a);
		return 32'(a) < MEM_BYTES;
	endfunction : in_memory

	// address decode
	assign hitLow = reg_hit(regAddr, `ADDR_START_LOW);
	assign hitMid = reg_hit(regAddr, `ADDR_START_MID);
	assign hitHigh = reg_hit(regAddr, `ADDR_START_HIGH);
	assign hitOffset = reg_hit(regAddr, `ADDR_LINE_OFFSET);
	assign hitWidth = reg_hit(regAddr, `ADDR_LINE_WIDTH);
	assign hitMode = reg_hit(regAddr, `ADDR_MODE);

	// start address bits 7:0
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			startLow_reg <= `RESET_BYTE;
		end else if (regWr && hitLow) begin
			startLow_reg <= regWrData;
		end
	end

	// start address bits 15:8
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			startMid_reg <= `RESET_BYTE;
		end else if (regWr && hitMid) begin
			startMid_reg <= regWrData;
		end
	end

	// start address bit 16, other bits kept for readback
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			startHigh_reg <= `RESET_BYTE;
		end else if (regWr && hitHigh) begin
			startHigh_reg <= regWrData;
		end
	end

	// extra words per line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lineOffset_reg <= `RESET_BYTE;
		end else if (regWr && hitOffset) begin
			lineOffset_reg <= regWrData;
		end
	end

	// physical line width in words
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lineWidth_reg <= `RESET_BYTE;
		end else if (regWr && hitWidth) begin
			lineWidth_reg <= regWrData;
		end
	end

	// orientation and color depth
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_reg <= mode_s'(`RESET_MODE);
		end else if (regWr && hitMode) begin
			mode_reg <= mode_s'(regWrData[2:0]);
		end
	end

	// readback selection, unmapped addresses read zero
	always_comb begin
		rdValue = `RESET_BYTE;
		if (hitLow) begin
			rdValue = startLow_reg;
		end else if (hitMid) begin
			rdValue = startMid_reg;
		end else if (hitHigh) begin
			rdValue = startHigh_reg;
		end else if (hitOffset) begin
			rdValue = lineOffset_reg;
		end else if (hitWidth) begin
			rdValue = lineWidth_reg;
		end else if (hitMode) begin
			rdValue = {5'h00, mode_reg};
		end
	end

	// read data stands one cycle after the strobe, else zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdData <= `RESET_BYTE;
		end else if (regRd) begin
			regRdData <= rdValue;
		end else begin
			regRdData <= `RESET_BYTE;
		end
	end

	// start word as the registers hold it now
	assign startWord = join_start(startHigh_reg, startMid_reg, startLow_reg);

	// frame snapshot so a start address write never shows mid-frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameStart_reg <= `RESET_ADDR;
		end else if (frameStart) begin
			frameStart_reg <= startWord;
		end
	end

	// mode held for the whole frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameMode_reg <= mode_s'(`RESET_MODE);
		end else if (frameStart) begin
			frameMode_reg <= mode_reg;
		end
	end

	// extra words held for the whole frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameOffset_reg <= `RESET_BYTE;
		end else if (frameStart) begin
			frameOffset_reg <= lineOffset_reg;
		end
	end

	// physical width held for the whole frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameWidth_reg <= `RESET_BYTE;
		end else if (frameStart) begin
			frameWidth_reg <= lineWidth_reg;
		end
	end

	// line to line advance in bytes
	assign stride = stride_bytes(frameWidth_reg, frameOffset_reg);

	// line address walks from the frame start down the image
	always_comb begin
		lineAddr_next = lineAddr_reg;
		if (firstLine_reg) begin
			lineAddr_next = fetchInfo.byteAddr;
		end else begin
			lineAddr_next = lineAddr_reg + stride;
		end
	end

	// first line marker, armed by every frame start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			firstLine_reg <= 1'b1;
		end else if (frameStart) begin
			firstLine_reg <= 1'b1;
		end else if (lineStart) begin
			firstLine_reg <= 1'b0;
		end
	end

	// current line address, frame start takes priority
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lineAddr_reg <= `RESET_LINE_ADDR;
		end else if (lineStart && !frameStart) begin
			lineAddr_reg <= lineAddr_next;
		end
	end

	// outputs for the refresh fetch side
	assign fetchInfo.byteAddr = start_bytes(frameMode_reg, frameStart_reg);
	assign fetchInfo.lineStrideBytes = stride;
	assign fetchInfo.panPixels = pan_step(frameMode_reg);
	assign lineAddr = lineAddr_reg;
	assign addrInRange = in_memory(lineAddr_reg);
endmodule : viewport_start
`default_nettype wire
